// file: lmc_host_model.sv
// serial bus host model for the light measurement control bench
// assumes a pulled-up sda line resolved by the bench
module lmc_host_model #(
  parameter int Q = 200
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data set mid-low, then one clock pulse
  task automatic put(input logic b);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
  endtask
  // release data, sample late in the high phase
  task automatic get(output logic b);
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #(Q + Q / 2) b = sda;
    #(Q / 2) scl = 1'b0;
  endtask
  task automatic stop;
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // start, then address with read direction
  task automatic send_addr(input logic [6:0] a);
    logic [7:0] v;
    v = {a, 1'b1};
    #(2 * Q) sda_low = 1'b1;
    #(2 * Q) scl = 1'b0;
    for (int i = 7; i >= 0; i--) put(v[i]);
  endtask
  task automatic read_word(input logic [6:0] a, output logic [15:0] d,
                           output logic ack_n);
    logic b;
    d = 16'h0000;
    send_addr(a);
    get(ack_n);
    if (ack_n === 1'b0) begin
      for (int i = 15; i >= 0; i--) begin
        get(b);
        d[i] = b;
        if (i == 8) put(1'b0);
      end
      put(1'b1);
    end
    stop;
  endtask
endmodule // lmc_host_model

// file: lmc_pkg.sv
// constants, types and helpers of the light measurement control block
// assumes a 10 MHz system clock; serial pins come from another domain
package lmc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TIMEOUT_MS = 28;
  localparam int SHORT_MS = 100;
  localparam int LONG_MS = 800;
  localparam int READY_MS = 3;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
  localparam int SHORT_CYC = SHORT_MS * CYC_PER_MS;
  localparam int LONG_CYC = LONG_MS * CYC_PER_MS;
  localparam int READY_CYC = READY_MS * CYC_PER_MS;

  // register indexes
  localparam logic [2:0] A_RESULT = 3'h0;
  localparam logic [2:0] A_CONFIG = 3'h1;
  localparam logic [2:0] A_LOW = 3'h2;
  localparam logic [2:0] A_HIGH = 3'h3;
  localparam logic [2:0] A_STAT = 3'h4;
  localparam logic [2:0] A_CLR = 3'h5;
  localparam logic [2:0] A_EN = 3'h6;

  // config fields
  localparam int CF_MODE = 0;
  localparam int CF_CT = 2;
  localparam int CF_RANGE = 3;
  localparam int CF_LATCH = 7;
  localparam int CF_FC = 8;
  localparam int CF_POL = 10;
  localparam int CF_FLO = 13;
  localparam int CF_FHI = 14;
  localparam logic [15:0] CFG_WMASK = 16'h07ff;
  localparam logic [15:0] CFG_RST = 16'h0060;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'hbfff;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [3:0] STAT_RST = 4'h0;
  localparam logic [3:0] RANGE_AUTO = 4'hc;
  localparam logic [3:0] RANGE_MAX = 4'hb;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;

  // status bits
  localparam int ST_READY = 0;
  localparam int ST_HI = 1;
  localparam int ST_LO = 2;
  localparam int ST_TMO = 3;

  localparam logic [6:0] DEV_ADDR = 7'h44;

  typedef enum logic [1:0] {CV_IDLE, CV_INTEG, CV_WAIT} lmc_conv_e;
  typedef enum logic [2:0] {IC_IDLE, IC_ADDR, IC_AACK, IC_TX, IC_TACK}
    lmc_ser_e;

  // exponent/mantissa result from a raw count
  function automatic logic [15:0] lmc_encode(input logic [19:0] adc,
                                             input logic [3:0] rng);
    logic [3:0] e;
    logic [19:0] m;
    e = (rng > RANGE_MAX) ? RANGE_MAX : rng;
    if (rng == RANGE_AUTO) begin
      e = 4'h8;
      for (int i = 8; i >= 0; i--) begin
        if ((adc >> i) < 20'h01000) e = 4'(i);
      end
    end
    m = adc >> e;
    return (m > 20'h00fff) ? {e, 12'hfff} : {e, m[11:0]};
  endfunction

  // linear value of a result word, for comparisons
  function automatic logic [26:0] lmc_lin(input logic [15:0] r);
    return {15'h0, r[11:0]} << r[15:12];
  endfunction
endpackage

// file: lmc_top.sv
// light measurement control: conversion timing, ranging, window alert,
// register port and serial target that reads out the result
// assumes adc_count on clk; scl/sda arrive asynchronously
// How it works
// R1: scl low 28 ms resets serial machine
// R2: integrate over 100 ms or 800 ms
// R3: conversion_time_select high picks 800 ms
// R4: start in shutdown until host configures
// R5: continuous and single-shot modes
// R6: range 1100b selects range automatically
// R7: result readable over serial bus
// R8: window compare drives alert pin
// R9: data ready 3 ms after integration end
// R10: mode 00 holds shutdown, no conversions
// R11: N consecutive same faults make event
// R12: single-shot returns mode to shutdown
//
// The register offsets and strobed register access are this design's own decisions.
module lmc_top #(
  parameter int TIMEOUT_CYC = lmc_pkg::TIMEOUT_CYC,
  parameter int SHORT_CYC = lmc_pkg::SHORT_CYC,
  parameter int LONG_CYC = lmc_pkg::LONG_CYC,
  parameter int READY_CYC = lmc_pkg::READY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [19:0] adc_count,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic alert_o,
  output logic alert_oe_n,
  output logic irq
);
  logic [15:0] cfg_r, low_r, high_r, result_r, sample_r;
  logic [3:0] stat_r, en_r;
  logic cfg_seen_r, ct_lat_r, flag_hi_r, flag_lo_r;
  logic [1:0] last_fault_r;
  logic [3:0] fcnt_r;
  logic [23:0] cnt_r;
  lmc_pkg::lmc_conv_e cv_st;

  // register decode
  wire cfg_wr = reg_wr && reg_addr == lmc_pkg::A_CONFIG;
  wire cfg_rd = reg_rd && reg_addr == lmc_pkg::A_CONFIG;
  wire clr_wr = reg_wr && reg_addr == lmc_pkg::A_CLR;
  wire [1:0] mode = cfg_r[lmc_pkg::CF_MODE +: 2];
  wire ct = cfg_r[lmc_pkg::CF_CT];
  wire [3:0] range = cfg_r[lmc_pkg::CF_RANGE +: 4];
  wire latch = cfg_r[lmc_pkg::CF_LATCH];
  wire [1:0] fc = cfg_r[lmc_pkg::CF_FC +: 2];
  wire pol = cfg_r[lmc_pkg::CF_POL];

  // conversion timing
  wire [23:0] integ_len = ct_lat_r ? 24'(LONG_CYC) : 24'(SHORT_CYC); // [R3]
  wire [23:0] integ_end = integ_len - 24'h1;
  wire [23:0] ready_end = integ_len + 24'(READY_CYC) - 24'h1; // [R9]
  wire start_conv = cv_st == lmc_pkg::CV_IDLE && mode != lmc_pkg::MODE_OFF;
  wire done_p = cv_st == lmc_pkg::CV_WAIT && cnt_r == ready_end;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cv_st <= lmc_pkg::CV_IDLE;
      cnt_r <= 24'h0;
      ct_lat_r <= 1'b0;
      sample_r <= lmc_pkg::RESULT_RST;
      result_r <= lmc_pkg::RESULT_RST;
    end else if (mode == lmc_pkg::MODE_OFF && !done_p) begin
      cv_st <= lmc_pkg::CV_IDLE; // [R10]
      cnt_r <= 24'h0;
    end else begin
      unique case (cv_st)
        lmc_pkg::CV_IDLE: begin
          if (start_conv) begin
            cv_st <= lmc_pkg::CV_INTEG;
            ct_lat_r <= ct;
            cnt_r <= 24'h0;
          end
        end
        lmc_pkg::CV_INTEG: begin
          cnt_r <= cnt_r + 24'h1;
          if (cnt_r == integ_end) begin
            sample_r <= lmc_pkg::lmc_encode(adc_count, range); // [R2] [R6]
            cv_st <= lmc_pkg::CV_WAIT;
          end
        end
        lmc_pkg::CV_WAIT: begin
          cnt_r <= cnt_r + 24'h1;
          if (done_p) begin
            result_r <= sample_r; // [R7] [R9]
            cnt_r <= 24'h0;
            ct_lat_r <= ct;
            cv_st <= mode[1] ? lmc_pkg::CV_INTEG : lmc_pkg::CV_IDLE; // [R5]
          end
        end
      endcase
    end
  end

  // window comparison and consecutive fault count
  wire hi_f = lmc_pkg::lmc_lin(sample_r) > lmc_pkg::lmc_lin(high_r);
  wire lo_f = lmc_pkg::lmc_lin(sample_r) < lmc_pkg::lmc_lin(low_r);
  wire [3:0] need = 4'h1 << fc;
  wire same = {hi_f, lo_f} == last_fault_r;
  wire [3:0] fcnt_nxt = !same ? 4'h1 : (fcnt_r >= need ? need : fcnt_r + 4'h1);
  wire evt = done_p && fcnt_nxt >= need; // [R11]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_r <= 4'h0;
      last_fault_r <= 2'h0;
      flag_hi_r <= 1'b0;
      flag_lo_r <= 1'b0;
    end else begin
      if (done_p) begin
        fcnt_r <= fcnt_nxt;
        last_fault_r <= {hi_f, lo_f};
      end
      if (evt) begin
        flag_hi_r <= hi_f || (latch && flag_hi_r); // [R11]
        flag_lo_r <= lo_f || (latch && flag_lo_r);
      end else if (cfg_rd && latch) begin
        flag_hi_r <= 1'b0;
        flag_lo_r <= 1'b0;
      end
    end
  end

  wire alert_act = flag_hi_r || flag_lo_r;
  assign alert_o = 1'b0;
  assign alert_oe_n = ~(alert_act ^ pol); // [R8]

  // serial target: synchronisers and edges
  logic [2:0] scl_q, sda_q;
  logic scl_s_r, sda_s_r, sda_low_r, ack_r, hi_next_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [18:0] tmo_r;
  lmc_pkg::lmc_ser_e ic_st;
  wire scl_n = (scl_q[1] == scl_q[2]) ? scl_q[2] : scl_s_r;
  wire sda_n = (sda_q[1] == sda_q[2]) ? sda_q[2] : sda_s_r;
  wire scl_rise = scl_n && !scl_s_r;
  wire scl_fall = !scl_n && scl_s_r;
  wire start_c = scl_s_r && scl_n && sda_s_r && !sda_n;
  wire stop_c = scl_s_r && scl_n && !sda_s_r && sda_n;
  wire tmo_p = !scl_s_r && tmo_r == 19'(TIMEOUT_CYC - 1);
  wire addr_ok = sh_r[7:1] == lmc_pkg::DEV_ADDR && sh_r[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
      tmo_r <= 19'h0;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      scl_s_r <= scl_n;
      sda_s_r <= sda_n;
      if (scl_s_r)
        tmo_r <= 19'h0;
      else if (tmo_r != 19'(TIMEOUT_CYC))
        tmo_r <= tmo_r + 19'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ic_st <= lmc_pkg::IC_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h0;
      sda_low_r <= 1'b0;
      ack_r <= 1'b0;
      hi_next_r <= 1'b0;
    end else if (tmo_p) begin
      ic_st <= lmc_pkg::IC_IDLE; // [R1]
      sda_low_r <= 1'b0;
    end else if (start_c) begin
      ic_st <= lmc_pkg::IC_ADDR;
      bit_r <= 4'h0;
      sda_low_r <= 1'b0;
    end else if (stop_c) begin
      ic_st <= lmc_pkg::IC_IDLE;
      sda_low_r <= 1'b0;
    end else begin
      unique case (ic_st)
        lmc_pkg::IC_IDLE: ;
        lmc_pkg::IC_ADDR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_n};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            ic_st <= addr_ok ? lmc_pkg::IC_AACK : lmc_pkg::IC_IDLE;
            sda_low_r <= addr_ok;
          end
        end
        lmc_pkg::IC_AACK: begin
          if (scl_fall) begin
            sh_r <= result_r[15:8]; // [R7]
            sda_low_r <= ~result_r[15];
            bit_r <= 4'h0;
            hi_next_r <= 1'b0;
            ic_st <= lmc_pkg::IC_TX;
          end
        end
        lmc_pkg::IC_TX: begin
          if (scl_rise) begin
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            sda_low_r <= 1'b0;
            ic_st <= lmc_pkg::IC_TACK;
          end else if (scl_fall) begin
            sh_r <= {sh_r[6:0], 1'b0};
            sda_low_r <= ~sh_r[6];
          end
        end
        lmc_pkg::IC_TACK: begin
          if (scl_rise) begin
            ack_r <= ~sda_n;
          end else if (scl_fall && ack_r) begin
            sh_r <= hi_next_r ? result_r[15:8] : result_r[7:0]; // [R7]
            sda_low_r <= hi_next_r ? ~result_r[15] : ~result_r[7];
            hi_next_r <= ~hi_next_r;
            bit_r <= 4'h0;
            ic_st <= lmc_pkg::IC_TX;
          end else if (scl_fall) begin
            ic_st <= lmc_pkg::IC_IDLE;
          end
        end
      endcase
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_n = ~sda_low_r;

  // registers, status and interrupt
  wire [3:0] ev = {tmo_p, evt && lo_f, evt && hi_f, done_p};
  wire [15:0] cfg_view = cfg_r | (16'(flag_hi_r) << lmc_pkg::CF_FHI)
                               | (16'(flag_lo_r) << lmc_pkg::CF_FLO);
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      lmc_pkg::A_RESULT: rd_mux = result_r;
      lmc_pkg::A_CONFIG: rd_mux = cfg_view;
      lmc_pkg::A_LOW: rd_mux = low_r;
      lmc_pkg::A_HIGH: rd_mux = high_r;
      lmc_pkg::A_STAT: rd_mux = {12'h0, stat_r};
      lmc_pkg::A_EN: rd_mux = {12'h0, en_r};
      default: rd_mux = 16'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= lmc_pkg::CFG_RST; // [R4]
      low_r <= lmc_pkg::LOW_RST;
      high_r <= lmc_pkg::HIGH_RST;
      stat_r <= lmc_pkg::STAT_RST;
      en_r <= lmc_pkg::STAT_RST;
      reg_rdata <= 16'h0;
      cfg_seen_r <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0;
      if (cfg_wr) begin
        cfg_r <= reg_wdata & lmc_pkg::CFG_WMASK;
        cfg_seen_r <= 1'b1;
      end else if (done_p && mode == lmc_pkg::MODE_ONE) begin
        cfg_r[lmc_pkg::CF_MODE +: 2] <= lmc_pkg::MODE_OFF; // [R12]
      end
      if (reg_wr && reg_addr == lmc_pkg::A_LOW) low_r <= reg_wdata;
      if (reg_wr && reg_addr == lmc_pkg::A_HIGH) high_r <= reg_wdata;
      if (reg_wr && reg_addr == lmc_pkg::A_EN) en_r <= reg_wdata[3:0];
      stat_r <= (stat_r & ~(clr_wr ? reg_wdata[3:0] : 4'h0)) | ev;
    end
  end
  assign irq = |(stat_r & en_r);

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_integ_end;
    cv_st == lmc_pkg::CV_INTEG ##1 cv_st == lmc_pkg::CV_WAIT;
  endsequence
  sequence s_auto_dark;
    cv_st == lmc_pkg::CV_INTEG && cnt_r == integ_end &&
      range == lmc_pkg::RANGE_AUTO && adc_count < 20'h01000;
  endsequence

  property p_tmo;
    tmo_p |=> ic_st == lmc_pkg::IC_IDLE && sda_oe_n;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout missed"); // [R1]
  property p_integ;
    s_integ_end |-> cnt_r == integ_len;
  endproperty
  a_integ: assert property (p_integ) else $error("bad window"); // [R2]
  property p_ct;
    start_conv && ct |=> integ_len == 24'(LONG_CYC);
  endproperty
  a_ct: assert property (p_ct) else $error("long window not used"); // [R3]
  property p_boot;
    !cfg_seen_r |-> cv_st == lmc_pkg::CV_IDLE;
  endproperty
  a_boot: assert property (p_boot) else $error("ran unconfigured"); // [R4]
  property p_cont;
    done_p && mode[1] |=> cv_st == lmc_pkg::CV_INTEG && cnt_r == 24'h0;
  endproperty
  a_cont: assert property (p_cont) else $error("no restart"); // [R5]
  property p_auto;
    s_auto_dark |=> sample_r[15:12] == 4'h0;
  endproperty
  a_auto: assert property (p_auto) else $error("auto range wrong"); // [R6]
  property p_tx;
    ic_st == lmc_pkg::IC_AACK && scl_fall && !tmo_p && !start_c && !stop_c
      |=> sh_r == $past(result_r[15:8]);
  endproperty
  a_tx: assert property (p_tx) else $error("result not sent"); // [R7]
  property p_alert;
    alert_act && !pol |-> !alert_oe_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven"); // [R8]
  property p_ready;
    s_integ_end ##1 (cv_st == lmc_pkg::CV_WAIT)[*2] |-> !done_p;
  endproperty
  a_ready: assert property (p_ready) else $error("ready too early"); // [R9]
  property p_off;
    mode == lmc_pkg::MODE_OFF && cv_st == lmc_pkg::CV_IDLE && !cfg_wr
      |=> cv_st == lmc_pkg::CV_IDLE;
  endproperty
  a_off: assert property (p_off) else $error("ran in shutdown"); // [R10]
  property p_evt;
    !evt && !cfg_rd |=> $stable(flag_hi_r) && $stable(flag_lo_r);
  endproperty
  a_evt: assert property (p_evt) else $error("flag moved"); // [R11]
  property p_one;
    done_p && mode == lmc_pkg::MODE_ONE && !cfg_wr
      |=> mode == lmc_pkg::MODE_OFF && cv_st == lmc_pkg::CV_IDLE;
  endproperty
  a_one: assert property (p_one) else $error("single shot ran on"); // [R12]
endmodule // lmc_top

// file: tb.sv
// testbench of lmc_top: registers, conversions, alert, serial readout
// assumes lmc_host_model on the serial pins; counts scaled down
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SH = 40;
  localparam int LG = 80;
  localparam int RD = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [19:0] adc_count = 20'h00000;
  logic [15:0] reg_rdata;
  logic sda_o, sda_oe_n, alert_o, alert_oe_n, irq, scl, host_low;
  wire logic sda_line = ~(host_low | ~sda_oe_n);
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [15:0] row_cfg [5] = '{16'h0011, 16'h0065, 16'h0069, 16'h0005,
    16'h0061};
  logic [19:0] row_adc [5] = '{20'h01234, 20'h12345, 20'h12345, 20'h12345,
    20'h00abc};
  logic [15:0] row_res [5] = '{16'h248d, 16'h591a, 16'hb024, 16'h0fff,
    16'h0abc};
  int row_cyc [5] = '{SH + RD, LG + RD, SH + RD, LG + RD, SH + RD};

  lmc_top #(.TIMEOUT_CYC(200), .SHORT_CYC(SH), .LONG_CYC(LG),
    .READY_CYC(RD)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_count(adc_count), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .alert_o(alert_o), .alert_oe_n(alert_oe_n), .irq(irq));
  lmc_host_model host (.scl(scl), .sda_low(host_low), .sda(sda_line));

  always #50 clk = ~clk;

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bit_chk(input string name, input logic s, input logic e);
    check(name, {15'h0000, s}, {15'h0000, e});
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e,
                        input string name);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(name, reg_rdata, e);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (irq !== 1'b1 && n < 300);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #500_000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    int n;
    logic [15:0] v;
    logic ack_n;
    repeat (10) @(posedge clk);
    bit_chk("rst_sda_oe_n", sda_oe_n, 1'b1);
    bit_chk("rst_alert_oe_n", alert_oe_n, 1'b1);
    bit_chk("rst_irq", irq, 1'b0);
    bit_chk("sda_o_low", sda_o, 1'b0);
    bit_chk("alert_o_low", alert_o, 1'b0);
    rst_n <= 1'b1;
    rd_chk(lmc_pkg::A_CONFIG, 16'h0060, "cfg_rst");
    rd_chk(lmc_pkg::A_HIGH, 16'hbfff, "high_rst");
    rd_chk(lmc_pkg::A_LOW, 16'h0000, "low_rst");
    rd_chk(lmc_pkg::A_RESULT, 16'h0000, "result_rst");
    idle(120);
    rd_chk(lmc_pkg::A_STAT, 16'h0000, "stat_idle");
    rd_chk(3'h7, 16'h0000, "unmapped");
    rd_chk(lmc_pkg::A_CLR, 16'h0000, "clr_read");
    wr(lmc_pkg::A_EN, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(lmc_pkg::A_CLR, 16'h000f);
      adc_count <= row_adc[i];
      wr(lmc_pkg::A_CONFIG, row_cfg[i]);
      wait_done(n);
      bit_chk("done_cyc", n >= row_cyc[i] - 1 && n <= row_cyc[i] + 1,
              1'b1);
      rd_chk(lmc_pkg::A_RESULT, row_res[i], "result");
      rd_chk(lmc_pkg::A_CONFIG, row_cfg[i] & 16'hfffc, "cfg_one");
    end
    wr(lmc_pkg::A_CONFIG, 16'h0012);
    wait_done(n);
    wr(lmc_pkg::A_CLR, 16'h0001);
    wait_done(n);
    bit_chk("cont_cyc", n <= SH + RD + 1, 1'b1);
    wr(lmc_pkg::A_CONFIG, 16'h0010);
    wr(lmc_pkg::A_CLR, 16'h000f);
    idle(120);
    rd_chk(lmc_pkg::A_STAT, 16'h0000, "stat_off");
    adc_count <= 20'h01234;
    wr(lmc_pkg::A_HIGH, 16'h0100);
    wr(lmc_pkg::A_EN, 16'h0003);
    wr(lmc_pkg::A_CONFIG, 16'h0112);
    wait_done(n);
    rd_chk(lmc_pkg::A_STAT, 16'h0001, "stat_first");
    wr(lmc_pkg::A_CLR, 16'h0001);
    wait_done(n);
    rd_chk(lmc_pkg::A_STAT, 16'h0003, "stat_second");
    bit_chk("alert_low", alert_oe_n, 1'b0);
    rd_chk(lmc_pkg::A_CONFIG, 16'h4112, "flag_high");
    wr(lmc_pkg::A_CONFIG, 16'h0512);
    #1 bit_chk("alert_pol", alert_oe_n, 1'b1);
    wr(lmc_pkg::A_EN, 16'h0000);
    #1 bit_chk("irq_mask", irq, 1'b0);
    wr(lmc_pkg::A_CONFIG, 16'h0000);
    wr(lmc_pkg::A_CLR, 16'h000f);
    rd_chk(lmc_pkg::A_STAT, 16'h0000, "stat_clr");
    wr(lmc_pkg::A_EN, 16'h0008);
    host.read_word(7'h44, v, ack_n);
    bit_chk("ser_ack", ack_n, 1'b0);
    check("ser_data", v, 16'h248d);
    host.read_word(7'h45, v, ack_n);
    bit_chk("ser_nack", ack_n, 1'b1);
    host.send_addr(7'h44);
    idle(20);
    bit_chk("ack_held", sda_oe_n, 1'b0);
    idle(250);
    bit_chk("tmo_free", sda_oe_n, 1'b1);
    bit_chk("tmo_irq", irq, 1'b1);
    host.stop();
    rd_chk(lmc_pkg::A_STAT, 16'h0008, "stat_tmo");
    // second reset in mid-run
    rst_n <= 1'b0;
    idle(2);
    bit_chk("rst2_irq", irq, 1'b0);
    bit_chk("rst2_sda_oe_n", sda_oe_n, 1'b1);
    rst_n <= 1'b1;
    rd_chk(lmc_pkg::A_STAT, 16'h0000, "stat_rst2");
    rd_chk(lmc_pkg::A_CONFIG, 16'h0060, "cfg_rst2");
    finish_test;
  end
endmodule // tb
